/* File: ivm_vector_map.sv */
`timescale 1ns/100ps
// reset and interrupt vector address generator for the core fetch unit
// assumes requests are level inputs already gated by enables and global flag
// assumes each peripheral keeps its request up until the vector has been taken
// assumes the core raises its acknowledge only while an offer stands
// request inputs carry no synchroniser: they come from logic on this same clock
// parameters pick the part size and where its boot region starts
// the small part ignores both boot options, whatever is strapped on them
// Functional notes
// (RULE_01) largest variant spaces vectors two words apart; smaller ones one word
// (RULE_02) smallest variant: reset always at 0x000, table never relocated
// (RULE_03) larger variants: reset follows boot fuse, table base follows relocate bit
// (RULE_04) every reset cause fetches vector 1, at 0x000 or the boot address (RULE_15)
// (RULE_05) external request zero to 0x001, external request one to 0x002
// (RULE_06) pin change zero/one/two to 0x003..0x005, watchdog to 0x006
// (RULE_07) second 8-bit timer: compare A 0x007, compare B 0x008, overflow 0x009
// (RULE_08) 16-bit timer: capture 0x00a, compare A 0x00b, B 0x00c, overflow 0x00d
// (RULE_09) first 8-bit timer: compare A 0x00e, compare B 0x00f, overflow 0x010
// (RULE_10) serial peripheral transfer complete vectors to 0x011
// (RULE_11) usart rx 0x012, tx buffer empty 0x013, tx complete 0x014
// (RULE_12) conversion complete 0x015, eeprom done 0x016
// (RULE_13) comparator 0x017, two-wire 0x018, program store done 0x019
// (RULE_14) relocated vectors add the boot region start address
// (RULE_15) programmed boot fuse sends reset to boot address, else 0x000
// (RULE_16) among pending requests the lowest vector number wins
module ivm_vector_map #(
    parameter logic [1:0] VARIANT = ivm_pkg::VAR_LARGE,
    parameter logic [ivm_pkg::PC_W-1:0] BOOT_START = ivm_pkg::BOOT_START_DEFAULT
) (
    input wire logic clk,
    input wire logic resetn,
    // reset causes, any one high restarts the core
    input wire logic ext_pin_reset,
    input wire logic power_on_reset,
    input wire logic brown_out_reset,
    input wire logic watchdog_reset,
    // straps and control
    input wire logic boot_reset_select_fuse,
    input wire logic vector_table_relocate_bit,
    // request lines in vector order
    input wire logic external_request_zero,
    input wire logic external_request_one,
    input wire logic pin_change_request_zero,
    input wire logic pin_change_request_one,
    input wire logic pin_change_request_two,
    input wire logic watchdog_timeout_request,
    // second 8-bit timer
    input wire logic timer2_compare_a_request,
    input wire logic timer2_compare_b_request,
    input wire logic timer2_overflow_request,
    // 16-bit timer
    input wire logic timer1_capture_request,
    input wire logic timer1_compare_a_request,
    input wire logic timer1_compare_b_request,
    input wire logic timer1_overflow_request,
    // first 8-bit timer
    input wire logic timer0_compare_a_request,
    input wire logic timer0_compare_b_request,
    input wire logic timer0_overflow_request,
    // serial, converter, memory and comparator requests
    input wire logic spi_done_request,
    input wire logic usart_rx_done_request,
    input wire logic tx_buffer_empty_request,
    input wire logic usart_tx_done_request,
    input wire logic adc_done_request,
    input wire logic eeprom_done_request,
    input wire logic comparator_request,
    input wire logic two_wire_serial_request,
    input wire logic program_store_done_request,
    // core takes the offered vector
    input wire logic vector_ack,
    output logic vector_valid_q,
    output logic [ivm_pkg::PC_W-1:0] vector_addr_q,
    output logic [4:0] vector_num_q,
    output logic reset_fetch_q
);
    logic [ivm_pkg::NUM_SRC-1:0] req;
    logic any_reset;
    logic any_req;
    logic [4:0] win_idx;
    logic [4:0] win_num_q;
    logic [ivm_pkg::PC_W-1:0] tbl_addr_q;
    logic relocate_ok;
    logic boot_ok;
    logic [ivm_pkg::PC_W-1:0] scaled;
    logic [ivm_pkg::PC_W-1:0] reset_target;
    ivm_pkg::ivm_state_e state_q;
    ivm_pkg::ivm_state_e state_d;
    // strobes decoded from the state and the handshake that the output registers share
    logic load_reset;
    logic load_offer;
    logic take_ack;
    logic [ivm_pkg::PC_W-1:0] offer_addr;

    // lowest set bit wins; bit 0 is vector 2
    // scanning from the top down lets the last hit, the lowest bit, stand
    // an empty vector gives index 0, which is harmless since nothing is offered then
    function automatic logic [4:0] lowest_index(input logic [ivm_pkg::NUM_SRC-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = ivm_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
                r = 5'(i);
        end
        return r;
    endfunction

    // table address (vector number minus one) to word address with per-variant spacing
    function automatic logic [ivm_pkg::PC_W-1:0] spaced(input logic [ivm_pkg::PC_W-1:0] a);
        if (VARIANT == ivm_pkg::VAR_LARGE)
            return a << ivm_pkg::STEP_SHIFT_LARGE; // RULE_01
        else
            return a << ivm_pkg::STEP_SHIFT_SMALL; // RULE_01
    endfunction

    // table address to fetch address, moved into the boot region when asked
    // the sum is cut to the counter width: a boot start near the top wraps
    function automatic logic [ivm_pkg::PC_W-1:0] relocated(input logic [ivm_pkg::PC_W-1:0] a,
        input logic move);
        if (move)
            return ivm_pkg::PC_W'(a + BOOT_START); // RULE_14
        else
            return a;
    endfunction

    // gather requests in table order, index n is vector n+2
    // external pins
    assign req[0] = external_request_zero; // RULE_05
    assign req[1] = external_request_one; // RULE_05

    // pin change groups and the watchdog time-out
    assign req[2] = pin_change_request_zero; // RULE_06
    assign req[3] = pin_change_request_one; // RULE_06
    assign req[4] = pin_change_request_two; // RULE_06
    assign req[5] = watchdog_timeout_request; // RULE_06

    // second 8-bit timer
    assign req[6] = timer2_compare_a_request; // RULE_07
    assign req[7] = timer2_compare_b_request; // RULE_07
    assign req[8] = timer2_overflow_request; // RULE_07

    // 16-bit timer
    assign req[9] = timer1_capture_request; // RULE_08
    assign req[10] = timer1_compare_a_request; // RULE_08
    assign req[11] = timer1_compare_b_request; // RULE_08
    assign req[12] = timer1_overflow_request; // RULE_08

    // first 8-bit timer
    assign req[13] = timer0_compare_a_request; // RULE_09
    assign req[14] = timer0_compare_b_request; // RULE_09
    assign req[15] = timer0_overflow_request; // RULE_09

    // serial peripheral
    assign req[16] = spi_done_request; // RULE_10

    // usart
    assign req[17] = usart_rx_done_request; // RULE_11
    assign req[18] = tx_buffer_empty_request; // RULE_11
    assign req[19] = usart_tx_done_request; // RULE_11

    // converter and eeprom
    assign req[20] = adc_done_request; // RULE_12
    assign req[21] = eeprom_done_request; // RULE_12

    // comparator, two-wire interface and program store
    assign req[22] = comparator_request; // RULE_13
    assign req[23] = two_wire_serial_request; // RULE_13
    assign req[24] = program_store_done_request; // RULE_13

    // all reset causes share vector 1
    assign any_reset = ext_pin_reset | power_on_reset | brown_out_reset | watchdog_reset; // RULE_04
    assign any_req = |req;
    assign win_idx = lowest_index(req); // RULE_16

    // the smallest variant has no boot region, so both options are forced off
    // the straps are read live; the core is expected to change them only while idle
    always_comb
    begin
        relocate_ok = 1'b0; // RULE_02
        boot_ok = 1'b0; // RULE_02
        if (VARIANT != ivm_pkg::VAR_SMALL)
        begin
            relocate_ok = vector_table_relocate_bit; // RULE_03
            boot_ok = (boot_reset_select_fuse == ivm_pkg::FUSE_PROGRAMMED); // RULE_03
        end
    end
    assign reset_target = boot_ok ? BOOT_START : ivm_pkg::RESET_ADDR; // RULE_15
    assign scaled = spaced(tbl_addr_q);

    // table lookup registered; the winner index is registered alongside
    // the extra cycle of latency buys a table read straight out of a register
    ivm_table #(
        .DEPTH(26)
    ) u_table (
        .clk(clk),
        .idx(5'(win_idx + 5'h01)),
        .addr_q(tbl_addr_q)
    );

    // winner's vector number, captured on the same edge as its table address
    // so the number and the address offered always belong to one source
    always_ff @(posedge clk)
    begin
        if (!resetn)
            win_num_q <= 5'h00;
        else
            win_num_q <= 5'(win_idx + 5'h02);
    end

    // strobes decoded from the state and the handshake, shared by the output registers
    assign load_reset = (state_q == ivm_pkg::ST_RESET);
    assign load_offer = (state_q == ivm_pkg::ST_HOLD) && !vector_valid_q;
    assign take_ack = vector_valid_q && vector_ack;
    assign offer_addr = relocated(scaled, relocate_ok); // RULE_14 RULE_01

    // states: reset fetch for one cycle, idle waiting for a request,
    // hold while the lookup settles and the offer waits for the core;
    // the offer is made on the first hold cycle, once the table register
    // has caught the winner chosen on the idle-to-hold edge
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ivm_pkg::ST_RESET:
                state_d = ivm_pkg::ST_IDLE;
            ivm_pkg::ST_IDLE:
                // a new winner is only taken once the last offer has gone
                if (any_req && !vector_valid_q)
                    state_d = ivm_pkg::ST_HOLD;
            ivm_pkg::ST_HOLD:
                if (vector_ack)
                    state_d = ivm_pkg::ST_IDLE;
            default:
                state_d = ivm_pkg::ST_RESET;
        endcase
    end

    // state register; every reset cause restarts at the reset fetch
    // and abandons any offer the core has not yet taken
    always_ff @(posedge clk)
    begin
        if (!resetn || any_reset) // RULE_04
            state_q <= ivm_pkg::ST_RESET;
        else
            state_q <= state_d;
    end

    // one-cycle marker that the address output holds the reset target
    always_ff @(posedge clk)
    begin
        if (!resetn || any_reset)
            reset_fetch_q <= 1'b0;
        else
            reset_fetch_q <= load_reset; // RULE_04
    end

    // offer flag: raised once the lookup has settled, dropped on the acknowledge edge
    // the core therefore never sees an offer for more cycles than it takes to answer
    always_ff @(posedge clk)
    begin
        if (!resetn || any_reset)
            vector_valid_q <= 1'b0;
        else if (load_reset)
            vector_valid_q <= 1'b0;
        else if (load_offer)
            vector_valid_q <= 1'b1;
        else if (take_ack)
            vector_valid_q <= 1'b0;
    end

    // fetch address; held unchanged while an offer waits for the core
    // requests that arrive meanwhile wait for the next idle cycle
    always_ff @(posedge clk)
    begin
        if (!resetn || any_reset)
            vector_addr_q <= ivm_pkg::RESET_ADDR;
        else if (load_reset)
            vector_addr_q <= reset_target; // RULE_15 RULE_02
        else if (load_offer)
            vector_addr_q <= offer_addr; // RULE_14
    end

    // vector number; reset shows vector 1, interrupts the registered winner
    always_ff @(posedge clk)
    begin
        if (!resetn || any_reset)
            vector_num_q <= 5'h00;
        else if (load_reset)
            vector_num_q <= 5'h01; // RULE_04
        else if (load_offer)
            vector_num_q <= win_num_q; // RULE_16
    end
endmodule

/* File: ivm_pkg.sv */
// package for the interrupt vector address map
// assumes a word-addressed program memory, 14-bit program counter
package ivm_pkg;
    localparam int unsigned PC_W = 14;
    localparam int unsigned NUM_SRC = 25; // interrupt sources, vectors 2..26
    localparam int unsigned IDX_W = 5;
    // variants
    localparam logic [1:0] VAR_SMALL = 2'h0;
    localparam logic [1:0] VAR_MID = 2'h1;
    localparam logic [1:0] VAR_LARGE = 2'h2;
    // fixed addresses
    localparam logic [PC_W-1:0] RESET_ADDR = 14'h0000;
    localparam logic [PC_W-1:0] BOOT_START_DEFAULT = 14'h0e00;
    // word spacing per vector
    localparam int unsigned STEP_SHIFT_LARGE = 1;
    localparam int unsigned STEP_SHIFT_SMALL = 0;
    // fuse polarity: programmed reads 0
    localparam logic FUSE_PROGRAMMED = 1'b0;
    typedef enum logic [2:0]
    {
        ST_RESET = 3'b001,
        ST_IDLE = 3'b010,
        ST_HOLD = 3'b100
    } ivm_state_e;
endpackage

/* File: ivm_table.sv */
`timescale 1ns/100ps
// table holding the 26 vector numbers' base table addresses
// registered read; one clock of latency
module ivm_table #(
    parameter int unsigned DEPTH = 26
) (
    input wire logic clk,
    input wire logic [4:0] idx,
    output logic [ivm_pkg::PC_W-1:0] addr_q
);
    // table address equals vector number minus one, in single-word units
    always_ff @(posedge clk)
    begin
        if (idx < 5'(DEPTH))
            addr_q <= ivm_pkg::PC_W'(idx);
        else
            addr_q <= ivm_pkg::RESET_ADDR;
    end
endmodule

/* File: ivm_vector_map_props.sv */
// checker for the vector map: reset targets, offer timing and holding
// assumes it is bound to ivm_vector_map with the same parameter values
`timescale 1ns/100ps
module ivm_vector_map_props #(
    parameter logic [1:0] VARIANT = ivm_pkg::VAR_LARGE,
    parameter logic [13:0] BOOT_START = ivm_pkg::BOOT_START_DEFAULT
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic boot_reset_select_fuse,
    input wire logic vector_table_relocate_bit,
    input wire logic external_request_zero,
    input wire logic vector_ack,
    input wire logic vector_valid_q,
    input wire logic [ivm_pkg::PC_W-1:0] vector_addr_q,
    input wire logic [4:0] vector_num_q,
    input wire logic reset_fetch_q
);
    // expected targets; the small part has no boot region to move to
    wire logic big = VARIANT != ivm_pkg::VAR_SMALL;
    wire logic [13:0] rst_t = (big && !boot_reset_select_fuse) ? BOOT_START : 14'h0000;
    wire logic [13:0] base = (big && vector_table_relocate_bit) ? BOOT_START : 14'h0000;
    wire logic [13:0] step = 14'(vector_num_q - 5'h01) << (VARIANT == ivm_pkg::VAR_LARGE);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence idle_req_s; !vector_valid_q && external_request_zero; endsequence
    sequence zero_offer_s; ##[1:4] vector_valid_q && vector_num_q == 5'h02; endsequence
    reset_target_a: assert property (reset_fetch_q |-> vector_addr_q == rst_t)
        else $error("reset fetch address wrong");
    reset_vector_a: assert property (reset_fetch_q |-> vector_num_q == 5'h01)
        else $error("reset fetch vector number wrong");
    reset_release_a: assert property ($rose(resetn) |-> ##[0:2] reset_fetch_q)
        else $error("no reset fetch after release");
    vector_addr_a: assert property (vector_valid_q |-> vector_addr_q == base + step)
        else $error("vector address wrong");
    vector_range_a: assert property (vector_valid_q |-> vector_num_q inside {[2:26]})
        else $error("vector number out of range");
    offer_hold_a: assert property (vector_valid_q && !vector_ack |=> vector_valid_q
        && $stable(vector_addr_q) && $stable(vector_num_q))
        else $error("offer changed before acknowledge");
    ack_release_a: assert property (vector_valid_q && vector_ack |=> !vector_valid_q)
        else $error("offer kept after acknowledge");
    zero_first_a: assert property (idle_req_s |-> zero_offer_s)
        else $error("request zero not offered first");
endmodule

/* File: ivm_core_model.sv */
// core fetch stand-in: takes each offered vector after a set delay
// assumes the offer stands until the acknowledge edge
`timescale 1ns/100ps
module ivm_core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic vector_valid_q,
    input wire logic [3:0] ack_delay,
    output logic vector_ack
);
    logic [3:0] wait_q;
    // one-cycle acknowledge, dropped at once so no later offer is taken early
    always_ff @(posedge clk)
    begin
        if (!resetn || vector_ack)
        begin
            vector_ack <= 1'b0;
            wait_q <= 4'h0;
        end
        else if (vector_valid_q)
        begin
            vector_ack <= wait_q == ack_delay;
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

/* File: interrupt_vector_address_map_bench.sv */
// bench for the vector map: every vector, both table places, resets, priority
// assumes a large part and a small part side by side, one core stand-in acking both
`timescale 1ns/100ps
module interrupt_vector_address_map_bench;
    localparam logic [13:0] BOOT = 14'h0c00;
    logic clk = 1'b0, resetn = 1'b0, fuse = 1'b1, reloc = 1'b0, ack, valid, rfetch;
    logic [3:0] rc = 4'h0, dly = 4'h0;
    logic [24:0] rq = '0;
    logic [13:0] addr;
    logic [4:0] num;
    logic valid_s, rfetch_s;
    logic [13:0] addr_s;
    logic [4:0] num_s;
    int n_mismatch = 0, n_compared = 0;
    `define CMP(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
        $display("CHECK FAILED t=%0t got %h want %h", $time, a, e); end end
    // 125 MHz clock
    initial forever #4 clk = ~clk;
    ivm_vector_map #(.VARIANT(ivm_pkg::VAR_LARGE), .BOOT_START(BOOT)) dut (
        .clk(clk), .resetn(resetn), .ext_pin_reset(rc[0]), .power_on_reset(rc[1]),
        .brown_out_reset(rc[2]), .watchdog_reset(rc[3]), .boot_reset_select_fuse(fuse),
        .vector_table_relocate_bit(reloc), .external_request_zero(rq[0]),
        .external_request_one(rq[1]), .pin_change_request_zero(rq[2]),
        .pin_change_request_one(rq[3]), .pin_change_request_two(rq[4]),
        .watchdog_timeout_request(rq[5]), .timer2_compare_a_request(rq[6]),
        .timer2_compare_b_request(rq[7]), .timer2_overflow_request(rq[8]),
        .timer1_capture_request(rq[9]), .timer1_compare_a_request(rq[10]),
        .timer1_compare_b_request(rq[11]), .timer1_overflow_request(rq[12]),
        .timer0_compare_a_request(rq[13]), .timer0_compare_b_request(rq[14]),
        .timer0_overflow_request(rq[15]), .spi_done_request(rq[16]),
        .usart_rx_done_request(rq[17]), .tx_buffer_empty_request(rq[18]),
        .usart_tx_done_request(rq[19]), .adc_done_request(rq[20]),
        .eeprom_done_request(rq[21]), .comparator_request(rq[22]),
        .two_wire_serial_request(rq[23]), .program_store_done_request(rq[24]),
        .vector_ack(ack), .vector_valid_q(valid), .vector_addr_q(addr),
        .vector_num_q(num), .reset_fetch_q(rfetch));
    // small part: same timing, so the large part's acknowledge serves it too
    ivm_vector_map #(.VARIANT(ivm_pkg::VAR_SMALL), .BOOT_START(BOOT)) dut_small (
        .clk(clk), .resetn(resetn), .ext_pin_reset(rc[0]), .power_on_reset(rc[1]),
        .brown_out_reset(rc[2]), .watchdog_reset(rc[3]), .boot_reset_select_fuse(fuse),
        .vector_table_relocate_bit(reloc), .external_request_zero(rq[0]),
        .external_request_one(rq[1]), .pin_change_request_zero(rq[2]),
        .pin_change_request_one(rq[3]), .pin_change_request_two(rq[4]),
        .watchdog_timeout_request(rq[5]), .timer2_compare_a_request(rq[6]),
        .timer2_compare_b_request(rq[7]), .timer2_overflow_request(rq[8]),
        .timer1_capture_request(rq[9]), .timer1_compare_a_request(rq[10]),
        .timer1_compare_b_request(rq[11]), .timer1_overflow_request(rq[12]),
        .timer0_compare_a_request(rq[13]), .timer0_compare_b_request(rq[14]),
        .timer0_overflow_request(rq[15]), .spi_done_request(rq[16]),
        .usart_rx_done_request(rq[17]), .tx_buffer_empty_request(rq[18]),
        .usart_tx_done_request(rq[19]), .adc_done_request(rq[20]),
        .eeprom_done_request(rq[21]), .comparator_request(rq[22]),
        .two_wire_serial_request(rq[23]), .program_store_done_request(rq[24]),
        .vector_ack(ack), .vector_valid_q(valid_s), .vector_addr_q(addr_s),
        .vector_num_q(num_s), .reset_fetch_q(rfetch_s));
    ivm_core_model core (.clk(clk), .resetn(resetn), .vector_valid_q(valid),
        .ack_delay(dly), .vector_ack(ack));
    task automatic summarize;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one reset cause (4 = reset input) for one cycle, then the fetch target
    task automatic check_reset(input int cause);
        @(negedge clk);
        if (cause < 4) rc[cause] = 1'b1; else resetn = 1'b0;
        @(negedge clk);
        rc = 4'h0;
        resetn = 1'b1;
        for (int i = 0; i < 3 && rfetch !== 1'b1; i++) @(negedge clk);
        `CMP(rfetch, 1'b1)
        `CMP(num, 5'h01)
        `CMP(addr, fuse ? 14'h0000 : BOOT)
        `CMP(rfetch_s, 1'b1)
        `CMP(addr_s, 14'h0000)
        repeat (2) @(negedge clk);
    endtask
    // waits for the taken offer; requests drop as a peripheral would clear them
    task automatic offer(input logic [4:0] en, input logic [13:0] ea);
        for (int i = 0; i < 40 && !(valid === 1'b1 && ack === 1'b1); i++) @(negedge clk);
        `CMP(num, en)
        `CMP(addr, ea)
        `CMP(num_s, en)
        `CMP(addr_s, 14'(en - 5'h01))
        rq = '0;
        repeat (3) @(negedge clk);
    endtask
    // each source alone, table moved on odd ones, acknowledge delay varied
    task automatic all_vectors;
        for (int i = 0; i < 25; i++)
        begin
            reloc = i[0];
            dly = i[3:0];
            rq[i] = 1'b1;
            offer(5'(i + 2), (reloc ? BOOT : 14'h0000) + 14'((i + 1) * 2));
        end
    endtask
    // several pending at once: lowest vector number must win
    task automatic pick_lowest;
        reloc = 1'b1;
        rq = 25'h1000500;
        offer(5'h0a, BOOT + 14'h0012);
        rq = '1;
        offer(5'h02, BOOT + 14'h0002);
    endtask
    // hang guard, far beyond the roughly 400 cycles the tests need
    initial
    begin
        #50000;
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        for (int f = 0; f < 2; f++)
            for (int c = 0; c < 5; c++)
            begin
                fuse = f[0];
                check_reset(c);
            end
        all_vectors();
        pick_lowest();
        summarize();
    end
endmodule
bind ivm_vector_map ivm_vector_map_props #(.VARIANT(VARIANT), .BOOT_START(BOOT_START)) chk (.*);
